// >>> design/cpu_reg_bus_if.sv
// link between the command decoder and the cpu register bank
`timescale 1ns/1ns
interface cpu_reg_bus_if;
  logic [2:0] regSel;
  logic regWrEn;
  logic [23:0] regWrData;
  logic exchange;
  logic wideSet;
  logic wideClear;
  logic pcIncrement;
  logic [23:0] regRdData;
  logic wideMode;
  logic [23:0] pcValue;
  modport ctrl (output regSel, regWrEn, regWrData, exchange, wideSet, wideClear, pcIncrement,
                input regRdData, wideMode, pcValue);
  modport bank (input regSel, regWrEn, regWrData, exchange, wideSet, wideClear, pcIncrement,
                output regRdData, wideMode, pcValue);
endinterface

// >>> design/cpu_register_bank.sv
// cpu register bank reached by debug read and write commands
`timescale 1ns/1ns
`include "debug_cpu_access_consts.svh"
module cpu_register_bank
  import debug_cpu_access_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  cpu_reg_bus_if.bank bus
);
  word24_t main_q [0:5];
  word24_t main_d [0:5];
  word24_t alt_q [0:3];
  word24_t alt_d [0:3];
  word24_t longSp_q, longSp_d;
  logic [15:0] shortSp_q, shortSp_d;
  word24_t pc_q, pc_d;
  logic wide_q, wide_d;

  always_comb begin
    main_d = main_q;
    alt_d = alt_q;
    longSp_d = longSp_q;
    shortSp_d = shortSp_q;
    pc_d = pc_q;
    wide_d = wide_q;
    if (bus.wideSet) wide_d = 1'b1;
    if (bus.wideClear) wide_d = 1'b0;
    if (bus.exchange) begin
      // memory base byte stays put; flags and accumulator swap, and registers 1 to 3 swap whole
      main_d[0][15:0] = alt_q[0][15:0];
      alt_d[0][15:0] = main_q[0][15:0];
      for (int i = 1; i < 4; i++) begin
        main_d[i] = alt_q[i];
        alt_d[i] = main_q[i];
      end
    end
    if (bus.pcIncrement) pc_d = pc_q + `PC_STEP;
    if (bus.regWrEn) begin
      case (bus.regSel)
        `REG_INDEX_SP: begin
          if (wide_q) longSp_d = bus.regWrData;
          else shortSp_d = bus.regWrData[15:0];
        end
        `REG_INDEX_PC: pc_d = bus.regWrData;
        default: main_d[bus.regSel] = bus.regWrData;
      endcase
    end
  end

  always_comb begin
    case (bus.regSel)
      `REG_INDEX_SP: bus.regRdData = wide_q ? longSp_q : {8'h00, shortSp_q};
      `REG_INDEX_PC: bus.regRdData = pc_q;
      default: bus.regRdData = main_q[bus.regSel];
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < 6; i++) main_q[i] <= `CPU_REG_RESET;
      for (int i = 0; i < 4; i++) alt_q[i] <= `CPU_REG_RESET;
      longSp_q <= `CPU_REG_RESET;
      shortSp_q <= 16'h0000;
      pc_q <= `CPU_REG_RESET;
      wide_q <= 1'b0;
    end else begin
      main_q <= main_d;
      alt_q <= alt_d;
      longSp_q <= longSp_d;
      shortSp_q <= shortSp_d;
      pc_q <= pc_d;
      wide_q <= wide_d;
    end
  end

  assign bus.wideMode = wide_q;
  assign bus.pcValue = pc_q;

  a_sp_short_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    bus.regWrEn && bus.regSel == `REG_INDEX_SP && !wide_q |=> shortSp_q == $past(bus.regWrData[15:0])
      && $stable(longSp_q)) else $error("short stack pointer write wrong");
endmodule // cpu_register_bank

// >>> design/debug_cpu_access.sv
// debug register space: master control, operand bytes and access commands
`timescale 1ns/1ns
`include "debug_cpu_access_consts.svh"
module debug_cpu_access
  import debug_cpu_access_pkg::*;
#(
  parameter int RESET_CYCLES = `SYSTEM_RESET_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic regWrStrobe,
  input wire logic [7:0] regWrAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] readResultUpper,
  output logic [7:0] readResultHigh,
  output logic [7:0] readResultLow,
  output logic systemResetReq,
  output logic wakeReq,
  output logic wideAddrMode,
  output logic [23:0] memAddr,
  output logic memRdEn,
  output logic memWrEn,
  output logic [7:0] memWrData,
  input wire logic [7:0] memRdData
);
  cpu_reg_bus_if bus ();

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  logic masterWrite, upperWrite, highWrite, lowWrite, commandWrite;
  logic isReadReg, isWriteReg;
  logic resetStart, resetActive, resetDone;

  assign masterWrite = regWrStrobe && regWrAddr == `ADDR_MASTER_CONTROL;
  assign upperWrite = regWrStrobe && regWrAddr == `ADDR_OPERAND_UPPER;
  assign highWrite = regWrStrobe && regWrAddr == `ADDR_OPERAND_HIGH;
  assign lowWrite = regWrStrobe && regWrAddr == `ADDR_OPERAND_LOW;
  assign commandWrite = regWrStrobe && regWrAddr == `ADDR_ACCESS_COMMAND;
  assign isReadReg = regWrData[7:3] == `CMD_READ_GROUP;
  assign isWriteReg = regWrData[7:3] == `CMD_WRITE_GROUP;

  ////////////////////////////////////////////////////////////////////////////////
  // master control register and system reset

  logic [7:0] master_q, master_d;
  logic wake_q, wake_d;
  logic sysReset_q, sysReset_d;

  assign resetStart = masterWrite && regWrData[`MASTER_RESET_BIT];

  always_comb begin
    master_d = master_q;
    // any master write pulls the cpu out of halt or sleep
    wake_d = masterWrite;
    sysReset_d = resetActive;
    if (resetDone) master_d[`MASTER_RESET_BIT] = 1'b0;
    // writing zero to the reset bit does not cut a running reset short
    if (masterWrite) begin
      master_d[6:0] = regWrData[6:0];
      if (regWrData[`MASTER_RESET_BIT]) master_d[`MASTER_RESET_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      master_q <= `MASTER_RESET_VALUE;
      wake_q <= 1'b0;
      sysReset_q <= 1'b0;
    end else begin
      master_q <= master_d;
      wake_q <= wake_d;
      sysReset_q <= sysReset_d;
    end
  end

  system_reset_timer #(
    .RESET_CYCLES(RESET_CYCLES)
  ) u_reset_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(resetStart),
    .active(resetActive),
    .done(resetDone)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // write operand bytes

  // no reset: contents are undefined until the host loads them
  word24_t operand_q, operand_d;

  always_comb begin
    operand_d = operand_q;
    if (upperWrite) operand_d[23:16] = regWrData;
    if (highWrite) operand_d[15:8] = regWrData;
    if (lowWrite) operand_d[7:0] = regWrData;
  end

  always_ff @(posedge sys_clk) begin
    operand_q <= operand_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command execution

  access_state_t state_q, state_d;
  word24_t result_q, result_d;
  logic [23:0] memAddr_q, memAddr_d;
  logic memRdEn_q, memRdEn_d;
  logic memWrEn_q, memWrEn_d;
  logic [7:0] memWrData_q, memWrData_d;
  logic idleCommand;
  logic resultLoad;

  // a command written while a memory read is in flight is dropped
  assign idleCommand = commandWrite && state_q == IDLE;

  always_comb begin
    state_d = state_q;
    result_d = result_q;
    resultLoad = 1'b0;
    memAddr_d = memAddr_q;
    memRdEn_d = 1'b0;
    memWrEn_d = 1'b0;
    memWrData_d = memWrData_q;
    bus.regSel = regWrData[2:0];
    bus.regWrEn = 1'b0;
    bus.regWrData = operand_q;
    bus.exchange = 1'b0;
    bus.wideSet = 1'b0;
    bus.wideClear = 1'b0;
    bus.pcIncrement = 1'b0;
    case (state_q)
      IDLE: begin
        if (idleCommand) begin
          if (isReadReg) begin
            result_d = bus.regRdData;
            resultLoad = 1'b1;
          end else if (isWriteReg) begin
            bus.regWrEn = 1'b1;
          end else begin
            case (regWrData)
              `CMD_SET_WIDE: bus.wideSet = 1'b1;
              `CMD_CLEAR_WIDE: bus.wideClear = 1'b1;
              `CMD_EXCHANGE: bus.exchange = 1'b1;
              `CMD_READ_MEM: begin
                memAddr_d = bus.pcValue;
                memRdEn_d = 1'b1;
                state_d = MEM_READ;
              end
              `CMD_WRITE_MEM: begin
                memAddr_d = bus.pcValue;
                memWrData_d = operand_q[7:0];
                memWrEn_d = 1'b1;
                bus.pcIncrement = 1'b1;
              end
              default: ;
            endcase
          end
        end
      end
      MEM_READ: state_d = MEM_TAKE;
      MEM_TAKE: begin
        result_d = {16'h0000, memRdData};
        resultLoad = 1'b1;
        bus.pcIncrement = 1'b1;
        state_d = IDLE;
      end
      default: state_d = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= IDLE;
      result_q <= {`RESULT_RESET, `RESULT_RESET, `RESULT_RESET};
      memAddr_q <= `CPU_REG_RESET;
      memRdEn_q <= 1'b0;
      memWrEn_q <= 1'b0;
      memWrData_q <= 8'h00;
    end else begin
      state_q <= state_d;
      result_q <= result_d;
      memAddr_q <= memAddr_d;
      memRdEn_q <= memRdEn_d;
      memWrEn_q <= memWrEn_d;
      memWrData_q <= memWrData_d;
    end
  end

  cpu_register_bank u_bank (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .bus(bus.bank)
  );

  assign readResultUpper = result_q[23:16];
  assign readResultHigh = result_q[15:8];
  assign readResultLow = result_q[7:0];
  assign systemResetReq = sysReset_q;
  assign wakeReq = wake_q;
  assign wideAddrMode = bus.wideMode;
  assign memAddr = memAddr_q;
  assign memRdEn = memRdEn_q;
  assign memWrEn = memWrEn_q;
  assign memWrData = memWrData_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_mem_read_cmd;
    idleCommand && regWrData == `CMD_READ_MEM;
  endsequence

  sequence s_mem_read_issue;
    memRdEn_q && memAddr_q == $past(bus.pcValue);
  endsequence

  sequence s_reset_request;
    masterWrite && regWrData[`MASTER_RESET_BIT];
  endsequence

  sequence s_pc_write_cmd;
    idleCommand && regWrData == {`CMD_WRITE_GROUP, `REG_INDEX_PC};
  endsequence

  sequence s_pc_read_cmd;
    idleCommand && regWrData == {`CMD_READ_GROUP, `REG_INDEX_PC};
  endsequence

  // flag and exchange codes land here too: none of them may touch memory or the results
  sequence s_quiet_cmd;
    idleCommand && !isReadReg && !isWriteReg && regWrData != `CMD_READ_MEM && regWrData != `CMD_WRITE_MEM;
  endsequence

  a_reset_bit_start: assert property (s_reset_request |=> master_q[`MASTER_RESET_BIT] ##1 systemResetReq)
    else $error("reset bit did not start a system reset");

  a_reset_self_clear: assert property (resetDone && !masterWrite |=> !master_q[`MASTER_RESET_BIT])
    else $error("reset bit did not clear at end of reset");

  a_reset_bit_hold: assert property (master_q[`MASTER_RESET_BIT] && !resetDone
    |=> master_q[`MASTER_RESET_BIT]) else $error("reset bit cleared before the reset ended");

  a_reset_zero_noop: assert property (masterWrite && !regWrData[`MASTER_RESET_BIT]
    && !master_q[`MASTER_RESET_BIT] |=> !master_q[`MASTER_RESET_BIT] && !resetActive)
    else $error("writing zero to the reset bit had an effect");

  a_wake_pulse: assert property (masterWrite |=> wakeReq ##1 (wakeReq == $past(masterWrite)))
    else $error("master write did not pulse wake");

  a_wake_quiet: assert property (!masterWrite |=> !wakeReq)
    else $error("wake pulse without a master write");

  a_master_reset_zero: assert property (@(posedge sys_clk) disable iff (1'b0)
    !rstn |=> master_q == `MASTER_RESET_VALUE && !systemResetReq)
    else $error("master control not zero after reset");

  a_operand_store: assert property (lowWrite |=> operand_q[7:0] == $past(regWrData))
    else $error("low operand byte not stored");

  a_operand_upper: assert property (upperWrite |=> operand_q[23:16] == $past(regWrData))
    else $error("upper operand byte not stored");

  a_operand_high: assert property (highWrite |=> operand_q[15:8] == $past(regWrData))
    else $error("high operand byte not stored");

  a_read_result: assert property (idleCommand && isReadReg |=> result_q == $past(bus.regRdData))
    else $error("read command result wrong");

  a_pc_read: assert property (s_pc_read_cmd |=> result_q == $past(bus.pcValue))
    else $error("program counter read wrong");

  a_write_pass: assert property (idleCommand && isWriteReg |-> bus.regWrEn && bus.regWrData == operand_q
    && bus.regSel == regWrData[2:0]) else $error("write command not passed to registers");

  a_pc_write: assert property (s_pc_write_cmd |=> bus.pcValue == $past(operand_q))
    else $error("program counter write wrong");

  a_wide_set: assert property (idleCommand && regWrData == `CMD_SET_WIDE |=> wideAddrMode)
    else $error("wide address flag not set");

  a_wide_clear: assert property (idleCommand && regWrData == `CMD_CLEAR_WIDE |=> !wideAddrMode)
    else $error("wide address flag not cleared");

  a_mem_read_seq: assert property (s_mem_read_cmd |=> s_mem_read_issue ##1 state_q == MEM_TAKE
    ##1 readResultLow == $past(memRdData) && bus.pcValue == $past(memAddr_q, 2) + `PC_STEP)
    else $error("memory read sequence wrong");

  a_mem_rd_pulse: assert property (memRdEn |=> !memRdEn)
    else $error("memory read strobe longer than one cycle");

  a_mem_write: assert property (idleCommand && regWrData == `CMD_WRITE_MEM |=> memWrEn && memAddr ==
    $past(bus.pcValue) && memWrData == $past(operand_q[7:0])) else $error("memory write wrong");

  a_mem_wr_pc: assert property (idleCommand && regWrData == `CMD_WRITE_MEM
    |=> bus.pcValue == $past(bus.pcValue) + `PC_STEP) else $error("program counter not stepped by write");

  a_reserved_quiet: assert property (s_quiet_cmd |=> !memRdEn && !memWrEn && $stable(result_q))
    else $error("non-access command touched memory or results");

  a_result_hold: assert property (!resultLoad |=> $stable(result_q))
    else $error("read result changed without a read");
endmodule // debug_cpu_access

// >>> design/debug_cpu_access_consts.svh
// constants of the debug cpu access command block
`ifndef DEBUG_CPU_ACCESS_CONSTS_SVH
`define DEBUG_CPU_ACCESS_CONSTS_SVH

`define ADDR_MASTER_CONTROL 8'h11
`define ADDR_OPERAND_UPPER 8'h13
`define ADDR_OPERAND_HIGH 8'h14
`define ADDR_OPERAND_LOW 8'h15
`define ADDR_ACCESS_COMMAND 8'h16

`define MASTER_RESET_VALUE 8'h00
`define MASTER_RESET_BIT 7

`define CMD_READ_GROUP 5'h00
`define CMD_WRITE_GROUP 5'h10
`define CMD_SET_WIDE 8'h08
`define CMD_CLEAR_WIDE 8'h09
`define CMD_EXCHANGE 8'h0A
`define CMD_READ_MEM 8'h0B
`define CMD_WRITE_MEM 8'h8B

`define REG_INDEX_AF 3'h0
`define REG_INDEX_SP 3'h6
`define REG_INDEX_PC 3'h7

`define CPU_REG_RESET 24'h000000
`define RESULT_RESET 8'h00
`define PC_STEP 24'h000001

`define SYS_CLK_PERIOD_NS 50
`define SYSTEM_RESET_TIME_NS 1000
`define SYSTEM_RESET_CYCLES ((`SYSTEM_RESET_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

// >>> design/debug_cpu_access_pkg.sv
// types of the debug cpu access command block
package debug_cpu_access_pkg;
  typedef logic [23:0] word24_t;
  typedef enum logic [1:0] {IDLE, MEM_READ, MEM_TAKE} access_state_t;
endpackage

// >>> design/system_reset_timer.sv
// timer that holds the system reset request for a fixed time
`timescale 1ns/1ns
`include "debug_cpu_access_consts.svh"
module system_reset_timer #(
  parameter int RESET_CYCLES = `SYSTEM_RESET_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic start,
  output logic active,
  output logic done
);
  localparam logic [15:0] LAST = 16'(RESET_CYCLES - 1);
  logic [15:0] count_q, count_d;
  logic active_q, active_d;
  logic done_q, done_d;

  always_comb begin
    count_d = count_q;
    active_d = active_q;
    done_d = 1'b0;
    if (start) begin
      // a new request restarts the full reset time
      count_d = 16'h0000;
      active_d = 1'b1;
    end else if (active_q) begin
      if (count_q == LAST) begin
        active_d = 1'b0;
        done_d = 1'b1;
      end else begin
        count_d = count_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count_q <= 16'h0000;
      active_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      count_q <= count_d;
      active_q <= active_d;
      done_q <= done_d;
    end
  end

  assign active = active_q;
  assign done = done_q;

  // the length follows the parameter, so the counter is checked step by step instead of a fixed repetition
  a_reset_length: assert property (@(posedge sys_clk) disable iff (!rstn)
    active_q && !start && count_q != LAST |=> active_q && count_q == $past(count_q) + 16'h0001)
    else $error("reset request ended before its full length");
endmodule // system_reset_timer

// >>> sim/debug_mem_model.sv
// memory model on the far side of the debug access block
`timescale 1ns/1ns
module debug_mem_model (
  input wire logic sys_clk,
  input wire logic [23:0] memAddr,
  input wire logic memRdEn,
  input wire logic memWrEn,
  input wire logic [7:0] memWrData,
  output logic [7:0] memRdData
);
  logic [7:0] store [256];
  initial begin
    memRdData = 8'hA5;
    for (int i = 0; i < 256; i++) begin
      store[i] = 8'(i) ^ 8'h5A;
    end
  end
  // answers one cycle after the read strobe; otherwise the bus toggles so stale data is never seen
  always @(posedge sys_clk) begin
    if (memRdEn === 1'b1) begin
      memRdData <= store[memAddr[7:0]];
    end else begin
      memRdData <= ~memRdData;
    end
    if (memWrEn === 1'b1) begin
      store[memAddr[7:0]] <= memWrData;
    end
  end
endmodule // debug_mem_model

// >>> sim/testbench.sv
// self-checking bench of the debug cpu access command block
`timescale 1ns/1ns
`include "debug_cpu_access_consts.svh"
module testbench
  import debug_cpu_access_pkg::*;
;
  // short reset time keeps the run brief
  localparam int RCYC = 4;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic regWrStrobe = 1'b0;
  logic [7:0] regWrAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] readResultUpper;
  logic [7:0] readResultHigh;
  logic [7:0] readResultLow;
  logic systemResetReq;
  logic wakeReq;
  logic wideAddrMode;
  logic [23:0] memAddr;
  logic memRdEn;
  logic memWrEn;
  logic [7:0] memWrData;
  logic [7:0] memRdData;
  word24_t result;
  word24_t regVal [8];
  int failCount = 0;
  int checked = 0;
  int cycles = 0;
  int wakeCount = 0;
  int resetHigh = 0;
  assign result = {readResultUpper, readResultHigh, readResultLow};

  debug_cpu_access #(.RESET_CYCLES(RCYC)) dut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .regWrStrobe(regWrStrobe),
    .regWrAddr(regWrAddr),
    .regWrData(regWrData),
    .readResultUpper(readResultUpper),
    .readResultHigh(readResultHigh),
    .readResultLow(readResultLow),
    .systemResetReq(systemResetReq),
    .wakeReq(wakeReq),
    .wideAddrMode(wideAddrMode),
    .memAddr(memAddr),
    .memRdEn(memRdEn),
    .memWrEn(memWrEn),
    .memWrData(memWrData),
    .memRdData(memRdData)
  );

  debug_mem_model mem (
    .sys_clk(sys_clk),
    .memAddr(memAddr),
    .memRdEn(memRdEn),
    .memWrEn(memWrEn),
    .memWrData(memWrData),
    .memRdData(memRdData)
  );

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic giveVerdict();
    if (failCount == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // counts wake pulses and reset request high cycles at the ports; a hang ends the run here
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (rstn === 1'b1 && wakeReq === 1'b1) begin
      wakeCount <= wakeCount + 1;
    end
    if (rstn === 1'b1 && systemResetReq === 1'b1) begin
      resetHigh <= resetHigh + 1;
    end
    if (cycles == 6000) begin
      failCount = failCount + 1;
      giveVerdict();
    end
  end

  task automatic check24(input string name, input word24_t exp, input word24_t got);
    checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      failCount++;
    end
  endtask

  task automatic checkCnt(input string name, input int exp, input int got);
    checked++;
    if (got != exp) begin
      $display("unexpected %s expected %0d seen %0d", name, exp, got);
      failCount++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrStrobe <= 1'b1;
    regWrAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrStrobe <= 1'b0;
  endtask

  // command then the longest walk (memory read) plus margin
  task automatic go(input logic [7:0] c);
    wr(`ADDR_ACCESS_COMMAND, c);
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic cmd(input logic [7:0] c, input word24_t op);
    wr(`ADDR_OPERAND_UPPER, op[23:16]);
    wr(`ADDR_OPERAND_HIGH, op[15:8]);
    wr(`ADDR_OPERAND_LOW, op[7:0]);
    go(c);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int w0;
    int r0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    check24("reset request idle", 24'h000000, {23'h000000, systemResetReq});
    for (int i = 0; i < 8; i++) begin
      regVal[i] = {8'h10 + 8'(i), 8'hA0 + 8'(i), 8'h50 + 8'(i)};
      cmd(8'h80 + 8'(i), regVal[i]);
    end
    for (int i = 0; i < 8; i++) begin
      go(8'(i));
      check24("register read", (i == 6) ? {8'h00, regVal[i][15:0]} : regVal[i], result);
    end
    // stack pointer selection follows the wide flag
    go(`CMD_SET_WIDE);
    check24("wide flag set", 24'h000001, {23'h000000, wideAddrMode});
    cmd(8'h86, 24'h3C5A7E);
    go(8'h06);
    check24("long stack", 24'h3C5A7E, result);
    go(`CMD_CLEAR_WIDE);
    check24("wide flag clear", 24'h000000, {23'h000000, wideAddrMode});
    go(8'h06);
    check24("short stack", {8'h00, regVal[6][15:0]}, result);
    // alternates are reached only through the exchange
    go(`CMD_EXCHANGE);
    go(8'h00);
    check24("alternate af", {regVal[0][23:16], 16'h0000}, result);
    go(8'h01);
    check24("alternate bc", 24'h000000, result);
    go(8'h04);
    check24("index kept", regVal[4], result);
    go(`CMD_EXCHANGE);
    go(8'h03);
    check24("main hl back", regVal[3], result);
    // reserved codes and unmapped offsets leave state and results alone
    go(8'h07);
    foreach (regVal[k]) begin
      if (k < 3) begin
        cmd(8'h88 + 8'(k), 24'hFFFFFF);
      end
    end
    wr(8'h17, 8'hFF);
    wr(8'h12, 8'hFF);
    check24("held result", regVal[7], result);
    go(8'h01);
    check24("bc after reserved", regVal[1], result);
    go(8'h07);
    check24("pc after reserved", regVal[7], result);
    // memory access at the program counter
    cmd(8'h87, 24'h000040);
    go(`CMD_READ_MEM);
    check24("memory read", {16'h0000, 8'h40 ^ 8'h5A}, result);
    go(8'h07);
    check24("pc after read", 24'h000041, result);
    cmd(`CMD_WRITE_MEM, 24'hFFFFC3);
    go(8'h07);
    check24("pc after write", 24'h000042, result);
    cmd(8'h87, 24'h000041);
    go(`CMD_READ_MEM);
    check24("memory written", 24'h0000C3, result);
    // master control: wake on every write, reset only for bit 7
    w0 = wakeCount;
    r0 = resetHigh;
    wr(`ADDR_MASTER_CONTROL, 8'h00);
    repeat (RCYC + 4) @(posedge sys_clk);
    checkCnt("wake pulses", w0 + 1, wakeCount);
    checkCnt("reset cycles", r0, resetHigh);
    wr(`ADDR_MASTER_CONTROL, 8'h80);
    repeat (RCYC + 4) @(posedge sys_clk);
    checkCnt("wake pulses", w0 + 2, wakeCount);
    checkCnt("reset cycles", r0 + RCYC, resetHigh);
    check24("reset cleared", 24'h000000, {23'h000000, systemResetReq});
    giveVerdict();
  end
endmodule // testbench
